// >>> inc/wdn_defines.svh
// constants for the watchdog nmi timer
`ifndef WDN_DEFINES_SVH
`define WDN_DEFINES_SVH

`define WDN_ADDR_W 16
`define WDN_DATA_W 4
`define WDN_CNT_W 10
`define WDN_EVT_W 2

`define WDN_ADDR_CTRL 16'hFF07
`define WDN_ADDR_STATUS 16'hFF08
`define WDN_ADDR_MASK 16'hFF09
`define WDN_ADDR_CNT_LO 16'hFF0A
`define WDN_ADDR_CNT_MID 16'hFF0B
`define WDN_ADDR_CNT_HI 16'hFF0C

`define WDN_BIT_CLEAR 0
`define WDN_BIT_ENABLE 1
`define WDN_CNT_LO_LSB 0
`define WDN_CNT_LO_MSB 3
`define WDN_CNT_MID_LSB 4
`define WDN_CNT_MID_MSB 7
`define WDN_CNT_HI_LSB 8
`define WDN_CNT_HI_MSB 9
`define WDN_CNT_HI_W 2
`define WDN_EVT_TIMEOUT 0
`define WDN_EVT_NMI_TAKEN 1

`define WDN_ENABLE_RST 1'h1
`define WDN_CNT_RST 10'h000
`define WDN_CNT_MAX 10'h3FF
`define WDN_CNT_ONE 10'h001
`define WDN_EVT_RST 2'h0
`define WDN_MASK_RST 2'h0
`define WDN_RDATA_ZERO 4'h0

`define WDN_OSC_LOW_HZ 32768
`define WDN_TICK_HZ 256
`define WDN_PRESCALE_W 7
`define WDN_PRESCALE_DIV (`WDN_OSC_LOW_HZ / `WDN_TICK_HZ)
`define WDN_PRESCALE_LAST 7'((`WDN_PRESCALE_DIV) - 1)
`define WDN_PRESCALE_RST 7'h00
`define WDN_PRESCALE_ONE 7'h01

`define WDN_NMI_VECTOR 16'h0100

`endif

// >>> inc/wdn_pkg.sv
// types for the watchdog nmi timer
package wdn_pkg;
  `include "wdn_defines.svh"

  typedef struct packed {
    logic [`WDN_ADDR_W-1:0] addr;
    logic [`WDN_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } wdn_bus_req_t;

  typedef enum logic [0:0] {
    WDN_NMI_IDLE = 1'b0,
    WDN_NMI_PENDING = 1'b1
  } wdn_nmi_state_t;
endpackage : wdn_pkg

// >>> src/wdn_tick_div.sv
// prescaler: low-speed oscillator edges down to the counting tick
`timescale 1ns/10ps
`include "wdn_defines.svh"
module wdn_tick_div
  import wdn_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_osc_edge,
  output logic o_tick
);
  logic [`WDN_PRESCALE_W-1:0] prescale;
  logic [`WDN_PRESCALE_W-1:0] next_prescale;
  logic tick;
  logic next_tick;

  always_comb
  begin
    next_prescale = prescale;
    next_tick = 1'b0;
    if (i_osc_edge)
    begin
      if (prescale == `WDN_PRESCALE_LAST)
      begin
        next_prescale = `WDN_PRESCALE_RST;
        next_tick = 1'b1;
      end
      else
      begin
        next_prescale = prescale + `WDN_PRESCALE_ONE;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      prescale <= `WDN_PRESCALE_RST;
      tick <= 1'b0;
    end
    else
    begin
      prescale <= next_prescale;
      tick <= next_tick;
    end
  end

  assign o_tick = tick;
endmodule : wdn_tick_div

// >>> src/wdn_watchdog.sv
// watchdog timer raising a non-maskable interrupt request to the cpu core
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
`include "wdn_defines.svh"
module wdn_watchdog
  import wdn_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_osc_low,
  input wdn_bus_req_t i_bus,
  input wire logic i_cpu_halted,
  input wire logic i_nmi_ack,
  output logic [`WDN_DATA_W-1:0] o_rdata,
  output logic o_nmi_req,
  output logic o_halt_release,
  output logic o_irq
);
  // reset release
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // oscillator pin into the clock domain
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic osc_edge;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end
    else
    begin
      osc_meta <= i_osc_low;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  assign osc_edge = osc_sync & ~osc_prev;

  logic tick;

  wdn_tick_div u_tick_div (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_osc_edge(osc_edge),
    .o_tick(tick)
  );

  // register decode
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic clear_req;

  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (i_bus.wr)
    begin
      if (i_bus.addr == `WDN_ADDR_CTRL)
      begin
        wr_ctrl = 1'b1;
      end
      else if (i_bus.addr == `WDN_ADDR_STATUS)
      begin
        wr_status = 1'b1;
      end
      else if (i_bus.addr == `WDN_ADDR_MASK)
      begin
        wr_mask = 1'b1;
      end
    end
  end

  // zero on the clear bit does nothing
  assign clear_req = wr_ctrl & i_bus.wdata[`WDN_BIT_CLEAR];

  // enable bit and counter
  logic enable;
  logic next_enable;
  logic [`WDN_CNT_W-1:0] count;
  logic [`WDN_CNT_W-1:0] next_count;
  logic overflow;

  always_comb
  begin
    next_enable = enable;
    next_count = count;
    overflow = 1'b0;
    if (wr_ctrl)
    begin
      next_enable = i_bus.wdata[`WDN_BIT_ENABLE];
    end
    // halt state has no say here
    if (enable && tick)
    begin
      if (count == `WDN_CNT_MAX)
      begin
        overflow = 1'b1;
        next_count = `WDN_CNT_RST;
      end
      else
      begin
        next_count = count + `WDN_CNT_ONE;
      end
    end
    if (clear_req)
    begin
      next_count = `WDN_CNT_RST;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable <= `WDN_ENABLE_RST;
      count <= `WDN_CNT_RST;
    end
    else
    begin
      enable <= next_enable;
      count <= next_count;
    end
  end

  // nmi request held until the cpu takes it or a control write clears the enable bit
  wdn_nmi_state_t nmi_state;
  wdn_nmi_state_t next_nmi_state;
  logic nmi_taken;

  always_comb
  begin
    next_nmi_state = nmi_state;
    nmi_taken = 1'b0;
    case (nmi_state)
      WDN_NMI_IDLE:
      begin
        if (overflow && !(wr_ctrl && !i_bus.wdata[`WDN_BIT_ENABLE]))
        begin
          next_nmi_state = WDN_NMI_PENDING;
        end
      end
      WDN_NMI_PENDING:
      begin
        if (wr_ctrl && !i_bus.wdata[`WDN_BIT_ENABLE])
        begin
          next_nmi_state = WDN_NMI_IDLE;
        end
        else if (i_nmi_ack && !overflow)
        begin
          nmi_taken = 1'b1;
          next_nmi_state = WDN_NMI_IDLE;
        end
        else if (i_nmi_ack)
        begin
          // fresh overflow beside the ack keeps it pending
          nmi_taken = 1'b1;
        end
      end
      default:
      begin
        next_nmi_state = WDN_NMI_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nmi_state <= WDN_NMI_IDLE;
    end
    else
    begin
      nmi_state <= next_nmi_state;
    end
  end

  assign o_nmi_req = (nmi_state == WDN_NMI_PENDING);
  assign o_halt_release = o_nmi_req & i_cpu_halted;

  // sticky events, mask, interrupt line
  logic [`WDN_EVT_W-1:0] evt_status;
  logic [`WDN_EVT_W-1:0] next_evt_status;
  logic [`WDN_EVT_W-1:0] evt_mask;
  logic [`WDN_EVT_W-1:0] next_evt_mask;
  logic [`WDN_EVT_W-1:0] evt_set;
  logic irq;
  logic next_irq;

  always_comb
  begin
    evt_set = `WDN_EVT_RST;
    evt_set[`WDN_EVT_TIMEOUT] = overflow;
    evt_set[`WDN_EVT_NMI_TAKEN] = nmi_taken;
    next_evt_status = evt_status;
    if (wr_status)
    begin
      next_evt_status = evt_status & ~i_bus.wdata[`WDN_EVT_W-1:0];
    end
    // set beats clear
    next_evt_status = next_evt_status | evt_set;
    next_evt_mask = evt_mask;
    if (wr_mask)
    begin
      next_evt_mask = i_bus.wdata[`WDN_EVT_W-1:0];
    end
    next_irq = |(next_evt_status & next_evt_mask);
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_status <= `WDN_EVT_RST;
      evt_mask <= `WDN_MASK_RST;
      irq <= 1'b0;
    end
    else
    begin
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
      irq <= next_irq;
    end
  end

  assign o_irq = irq;

  // read data, one cycle after the strobe
  logic [`WDN_DATA_W-1:0] rdata;
  logic [`WDN_DATA_W-1:0] next_rdata;

  always_comb
  begin
    next_rdata = `WDN_RDATA_ZERO;
    if (i_bus.rd)
    begin
      if (i_bus.addr == `WDN_ADDR_CTRL)
      begin
        // clear and upper bits stay zero
        next_rdata[`WDN_BIT_ENABLE] = enable;
      end
      else if (i_bus.addr == `WDN_ADDR_STATUS)
      begin
        next_rdata[`WDN_EVT_W-1:0] = evt_status;
      end
      else if (i_bus.addr == `WDN_ADDR_MASK)
      begin
        next_rdata[`WDN_EVT_W-1:0] = evt_mask;
      end
      else if (i_bus.addr == `WDN_ADDR_CNT_LO)
      begin
        next_rdata = count[`WDN_CNT_LO_MSB:`WDN_CNT_LO_LSB];
      end
      else if (i_bus.addr == `WDN_ADDR_CNT_MID)
      begin
        next_rdata = count[`WDN_CNT_MID_MSB:`WDN_CNT_MID_LSB];
      end
      else if (i_bus.addr == `WDN_ADDR_CNT_HI)
      begin
        next_rdata[`WDN_CNT_HI_W-1:0] = count[`WDN_CNT_HI_MSB:`WDN_CNT_HI_LSB];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= `WDN_RDATA_ZERO;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;
endmodule : wdn_watchdog

// >>> dv/wdn_watchdog_sva.sv
// port-level assertions for the watchdog nmi timer
`timescale 1ns/10ps
`include "wdn_defines.svh"
module wdn_watchdog_sva
  import wdn_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_osc_low,
  input wdn_bus_req_t i_bus,
  input wire logic i_cpu_halted,
  input wire logic i_nmi_ack,
  input wire logic [`WDN_DATA_W-1:0] o_rdata,
  input wire logic o_nmi_req,
  input wire logic o_halt_release,
  input wire logic o_irq
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = i_bus.wr && i_bus.addr == `WDN_ADDR_CTRL;
  assign ctl_rd = i_bus.rd && i_bus.addr == `WDN_ADDR_CTRL;
  // enable value last written over the bus
  logic en_seen;
  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      en_seen <= `WDN_ENABLE_RST;
    end
    else if (ctl_wr)
    begin
      en_seen <= i_bus.wdata[`WDN_BIT_ENABLE];
    end
  end
  rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 4'h0)
    else $error("read data not zero outside a read");
  ctrl_fixed_a: assert property (ctl_rd |=> o_rdata[3:2] == 2'h0 && o_rdata[0] == 1'h0)
    else $error("fixed control bits not zero");
  en_back_a: assert property (ctl_rd |=> o_rdata[1] == en_seen)
    else $error("enable does not read back");
  dis_drop_a: assert property (ctl_wr && !i_bus.wdata[1] |=> !o_nmi_req)
    else $error("nmi survives disable");
  nmi_hold_a: assert property (o_nmi_req && !i_nmi_ack && !ctl_wr |=> o_nmi_req)
    else $error("nmi request dropped");
  nmi_fall_a: assert property ($fell(o_nmi_req) |-> $past(i_nmi_ack) || $past(ctl_wr))
    else $error("nmi request fell without cause");
  halt_rel_a: assert property (o_halt_release == (o_nmi_req && i_cpu_halted))
    else $error("halt release wrong");
  cnt_hi_a: assert property (i_bus.rd && i_bus.addr == `WDN_ADDR_CNT_HI |=> o_rdata[3:2] == 2'h0)
    else $error("counter wider than ten bits");
endmodule : wdn_watchdog_sva

bind wdn_watchdog wdn_watchdog_sva chk_u (.i_mclk, .i_rstn, .i_osc_low, .i_bus,
  .i_cpu_halted, .i_nmi_ack, .o_rdata, .o_nmi_req, .o_halt_release, .o_irq);

// >>> dv/wdn_cpu_model.sv
// cpu core nmi input model
`timescale 1ns/10ps
`include "wdn_defines.svh"
module wdn_cpu_model
  import wdn_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_nmi_req,
  input wire logic i_halt_release,
  input wire logic i_sp_paired,
  input wire logic i_halt_cmd,
  output logic o_nmi_ack,
  output logic o_halted,
  output logic [15:0] o_pc
);
  logic masked;
  always_ff @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn)
    begin
      masked <= 1'h1;
      o_nmi_ack <= 1'h0;
      o_halted <= 1'h0;
      o_pc <= 16'h0000;
    end
    else
    begin
      if (i_sp_paired)
        masked <= 1'h0;
      // interrupt enable flag not consulted
      o_nmi_ack <= i_nmi_req && !masked && !o_nmi_ack;
      if (o_nmi_ack)
        o_pc <= `WDN_NMI_VECTOR;
      o_halted <= i_halt_cmd || (o_halted && !i_halt_release);
    end
endmodule : wdn_cpu_model

// >>> dv/testbench.sv
// self-checking bench for the watchdog nmi timer
`timescale 1ns/10ps
`include "wdn_defines.svh"
module testbench;
  import wdn_pkg::*;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic run = 1'h0;
  logic sp = 1'h0;
  logic hlt = 1'h0;
  logic [1:0] ph = 2'h0;
  wdn_bus_req_t bus = '0;
  logic ack, halted, nmi, rel, irq;
  logic [3:0] rdata;
  logic [3:0] d;
  logic [9:0] c;
  logic [9:0] c0;
  logic [15:0] pc;
  int errors = 0;
  int checks_done = 0;
  always #50 clk = ~clk;
  // low-speed oscillator at a quarter of the clock
  always @(posedge clk)
    if (run)
      ph <= ph + 2'h1;
  wdn_watchdog dut_u (.i_mclk(clk), .i_rstn(rstn), .i_osc_low(ph[1]), .i_bus(bus),
    .i_cpu_halted(halted), .i_nmi_ack(ack), .o_rdata(rdata), .o_nmi_req(nmi),
    .o_halt_release(rel), .o_irq(irq));
  wdn_cpu_model cpu_u (.i_mclk(clk), .i_rstn(rstn), .i_nmi_req(nmi), .i_halt_release(rel),
    .i_sp_paired(sp), .i_halt_cmd(hlt), .o_nmi_ack(ack), .o_halted(halted), .o_pc(pc));
  task complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task chk_nib(input string n, input logic [3:0] e, input logic [3:0] s);
    checks_done++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk_nib
  task chk_cnt(input logic [9:0] e);
    checks_done++;
    if (c !== e)
    begin
      errors++;
      $display("[FAIL] counter expected %h seen %h", e, c);
    end
  endtask : chk_cnt
  task wr(input logic [15:0] a, input logic [3:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task rd(input logic [15:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 4'h0, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask : rd
  task rc;
    rd(`WDN_ADDR_CNT_LO);
    c[3:0] = d;
    rd(`WDN_ADDR_CNT_MID);
    c[7:4] = d;
    rd(`WDN_ADDR_CNT_HI);
    c[9:8] = d[1:0];
  endtask : rc
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    rd(`WDN_ADDR_CTRL);
    chk_nib("ctrl", 4'h2, d);
    rd(`WDN_ADDR_STATUS);
    chk_nib("status", 4'h0, d);
    rd(16'hFF06);
    chk_nib("unmapped", 4'h0, d);
    rc;
    chk_cnt(10'h000);
    $display("test reset done");
    run <= 1'h1;
    sp <= 1'h1;
    hlt <= 1'h1;
    // ten ticks of 128 oscillator edges, counted while halted
    repeat (10 * 512 + 20) @(posedge clk);
    rc;
    chk_cnt(10'h00A);
    $display("test counting done");
    wr(`WDN_ADDR_CTRL, 4'hC);
    rd(`WDN_ADDR_CTRL);
    chk_nib("ctrl", 4'h0, d);
    rc;
    c0 = c;
    repeat (3 * 512) @(posedge clk);
    rc;
    chk_cnt(c0);
    wr(`WDN_ADDR_CTRL, 4'h1);
    rd(`WDN_ADDR_CTRL);
    chk_nib("ctrl", 4'h0, d);
    rc;
    chk_cnt(10'h000);
    wr(`WDN_ADDR_CTRL, 4'hE);
    rd(`WDN_ADDR_CTRL);
    chk_nib("ctrl", 4'h2, d);
    $display("test control done");
    wr(`WDN_ADDR_MASK, 4'hF);
    rd(`WDN_ADDR_MASK);
    chk_nib("mask", 4'h3, d);
    wr(`WDN_ADDR_STATUS, 4'h3);
    rd(`WDN_ADDR_STATUS);
    chk_nib("status", 4'h0, d);
    chk_nib("irq", 4'h0, {3'h0, irq});
    $display("test interrupt regs done");
    repeat (600) @(posedge clk);
    rc;
    chk_cnt(10'h001);
    wr(`WDN_ADDR_CTRL, 4'h3);
    rc;
    chk_cnt(10'h000);
    repeat (400) @(posedge clk);
    rc;
    chk_cnt(10'h001);
    chk_nib("nmi", 4'h0, {3'h0, nmi});
    chk_nib("halt release", 4'h0, {3'h0, rel});
    $display("test restart done");
    complete_run;
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    complete_run;
  end
endmodule : testbench
